// ==== hw/eil_defs.svh ====
`ifndef EIL_DEFS_SVH
`define EIL_DEFS_SVH
// register byte address on the bus
`define EIL_ADDR_SCR        8'h00
`define EIL_ADDR_CPU        8'h04
// status/control field positions
`define EIL_BIT_OSC1        1
`define EIL_BIT_OSC2        2
`define EIL_BIT_FCLR        3
`define EIL_BIT_EXTEN       4
`define EIL_BIT_PEND        7
`define EIL_SCR_RESET       8'h14
`define EIL_SCR_WMASK       8'h16
// cpu control register fields
`define EIL_BIT_GMASK       0
`define EIL_BIT_SWTRAP      1
`define EIL_BIT_DONE        2
`define EIL_BIT_RETI        3
`define EIL_BIT_INSVC       4
`endif

// ==== hw/eil_pkg.sv ====
package eil_pkg;
  typedef enum logic [1:0] {
    EIL_RUN,
    EIL_STACK,
    EIL_VECTOR
  } eil_state_t;
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [7:0] dat;
  } eil_wb_req_t;
  typedef struct packed {
    logic       osc_int_en;
    logic       osc_ext_en;
    logic       osc_ext_sel;
  } eil_osc_t;
endpackage

// ==== hw/eil_ext_irq.sv ====
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "eil_defs.svh"
// Function
// [R01] taking service stacks registers, sets global mask, then fetches vector
// [R02] return from service restores the stacked global mask
// [R03] software trap raises service regardless of mask and enable
// [R04] external sources blocked while mask set or external enable clear
// [R05] at instruction end: latch set, mask clear, enable set starts service
// [R06] request latch clears at vector fetch; new requests latch meanwhile
// [R07] level mode: falling edge or low sets latch; edge mode: edge only
// [R08] edge mode pin: next request only after pin high then low again
// [R09] level mode: request stays while pin held low
// [R10] port option set: port rising edges set the same latch
// [R11] level mode: port rising edge or high sets latch, persists
// [R12] edge mode port: next request only after low then high again
// [R13] any port pin high masks pin and other ports until all low
// [R14] interrupt pin low masks port pins until it returns high
// [R15] unused bits read zero; reset sets enable and second osc bit
// [R16] external enable is read/write, one enables
// [R17] first osc bit clear: internal clocks; only first set: external alone
// [R18] both osc bits set: external runs, internal still clocks cpu
// [R19] pending flag read-only, set by pending request, reset clears
// [R20] pending flag clears at vector fetch or flag-clear write
// [R21] flag-clear bit write-only, one clears flag, reads zero
// [R22] request held under global mask, serviced when mask clears
// [R23] pins synchronised before edge detection, one set per transition
module eil_ext_irq
  import eil_pkg::*;
#(
  parameter int unsigned NPORT = 4
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              irq_n_i,
  input  wire logic [NPORT-1:0]  port_pins_i,
  input  wire logic              level_mode_i,
  input  wire logic              port_interrupt_option_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   vector_fetch_o,
  output logic                   stack_push_o,
  output logic                   swtrap_vec_o,
  output eil_osc_t               osc_o
);

  eil_wb_req_t      req;
  eil_state_t       state_r;
  logic [2:0]       irq_sync_r;
  logic [NPORT-1:0] p_s0_r;
  logic [NPORT-1:0] p_s1_r;
  logic [NPORT-1:0] p_s2_r;
  logic             irq_lvl_r;
  logic [NPORT-1:0] p_lvl_r;
  logic             pend_r;
  logic             exten_r;
  logic             osc1_r;
  logic             osc2_r;
  logic             gmask_r;
  logic             saved_mask_r;
  logic             trap_r;
  logic             svc_trap_r;
  logic             insvc_r;
  logic             irq_lvl_nxt;
  logic [NPORT-1:0] p_lvl_nxt;
  logic             any_port;
  logic             irq_fall;
  logic [NPORT-1:0] p_rise;
  logic             set_req;
  logic             wr_scr;
  logic             wr_cpu;
  logic             fclr;
  logic             take_ext;
  logic             done_pulse;
  logic             reti_pulse;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i[7:0]};

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sync_r <= 3'h7;
      p_s0_r     <= '0;
      p_s1_r     <= '0;
      p_s2_r     <= '0;
    end else if (ce_i) begin
      irq_sync_r <= {irq_sync_r[1:0], irq_n_i};
      p_s0_r     <= port_pins_i;
      p_s1_r     <= p_s0_r;
      p_s2_r     <= p_s1_r;
    end
  end

  // filtered levels hold until stages agree
  always_comb begin
    irq_lvl_nxt = irq_lvl_r;
    if (irq_sync_r[1] == irq_sync_r[2]) begin
      irq_lvl_nxt = irq_sync_r[1];
    end
    for (int i = 0; i < NPORT; i++) begin
      p_lvl_nxt[i] = (p_s1_r[i] == p_s2_r[i]) ? p_s1_r[i] : p_lvl_r[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_lvl_r <= 1'b1;
      p_lvl_r   <= '0;
    end else if (ce_i) begin
      irq_lvl_r <= irq_lvl_nxt; // R23
      p_lvl_r   <= p_lvl_nxt; // R23
    end
  end

  // ports ignored when the option is off
  assign any_port = port_interrupt_option_i && (|p_lvl_r);
  assign irq_fall = irq_lvl_r && !irq_lvl_nxt; // R08
  assign p_rise   = ~p_lvl_r & p_lvl_nxt; // R12

  always_comb begin
    set_req = 1'b0;
    if (!any_port) begin // R13
      set_req = irq_fall || (level_mode_i && !irq_lvl_r); // R07 R09
    end
    if (port_interrupt_option_i && irq_lvl_r) begin // R14 R10
      // a port edge while others are high is still swallowed by R13
      if (!(|(p_lvl_r & ~p_rise))) begin // R13
        set_req = set_req || (|p_rise); // R10
      end
      set_req = set_req || (level_mode_i && (|p_lvl_r)); // R11
    end
  end

  // writes land at the ack edge, while the master still holds the request
  assign wr_scr     = req.cyc && req.stb && req.we && req.sel[0] && wb_ack_o &&
                      (req.adr == `EIL_ADDR_SCR);
  assign wr_cpu     = req.cyc && req.stb && req.we && req.sel[0] && wb_ack_o &&
                      (req.adr == `EIL_ADDR_CPU);
  assign fclr       = wr_scr && req.dat[`EIL_BIT_FCLR]; // R21
  assign done_pulse = wr_cpu && req.dat[`EIL_BIT_DONE];
  assign reti_pulse = wr_cpu && req.dat[`EIL_BIT_RETI];
  assign take_ext   = done_pulse && pend_r && !gmask_r && exten_r; // R05 R04 R22

  // set wins over clear so a request at the clear is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= 1'b0; // R19
    end else if (ce_i) begin
      if (set_req) begin
        pend_r <= 1'b1; // R19
      end else if ((state_r == EIL_VECTOR && !svc_trap_r) || fclr) begin
        pend_r <= 1'b0; // R06 R20
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exten_r <= 1'b1; // R15
      osc1_r  <= 1'b0;
      osc2_r  <= 1'b1; // R15
    end else if (ce_i && wr_scr) begin
      exten_r <= req.dat[`EIL_BIT_EXTEN]; // R16
      osc1_r  <= req.dat[`EIL_BIT_OSC1];
      osc2_r  <= req.dat[`EIL_BIT_OSC2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_o <= '{osc_int_en: 1'b1, osc_ext_en: 1'b0, osc_ext_sel: 1'b0};
    end else if (ce_i) begin
      osc_o.osc_int_en  <= !osc1_r || osc2_r; // R17 R18
      osc_o.osc_ext_en  <= osc1_r; // R17 R18
      osc_o.osc_ext_sel <= osc1_r && !osc2_r; // R17
    end
  end

  // stand-in sequencer for the cpu's interrupt entry; return is only the mask restore in the next block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= EIL_RUN;
      svc_trap_r <= 1'b0;
      trap_r     <= 1'b0;
    end else if (ce_i) begin
      if (wr_cpu && req.dat[`EIL_BIT_SWTRAP]) begin
        trap_r <= 1'b1;
      end
      unique case (state_r)
        EIL_RUN: begin
          if (done_pulse && (trap_r || req.dat[`EIL_BIT_SWTRAP])) begin
            state_r    <= EIL_STACK; // R03
            svc_trap_r <= 1'b1;
            trap_r     <= 1'b0;
          end else if (take_ext) begin
            state_r    <= EIL_STACK; // R05
            svc_trap_r <= 1'b0;
          end
        end
        EIL_STACK: begin
          state_r <= EIL_VECTOR; // R01
        end
        EIL_VECTOR: begin
          state_r <= EIL_RUN; // R01
        end
        default: begin
          state_r <= EIL_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gmask_r      <= 1'b1;
      saved_mask_r <= 1'b1;
      insvc_r      <= 1'b0;
    end else if (ce_i) begin
      if (state_r == EIL_STACK) begin
        saved_mask_r <= gmask_r; // R01
        gmask_r      <= 1'b1; // R01
        insvc_r      <= 1'b1;
      end else if (reti_pulse && insvc_r) begin
        gmask_r <= saved_mask_r; // R02
        insvc_r <= 1'b0;
      end else if (wr_cpu) begin
        gmask_r <= req.dat[`EIL_BIT_GMASK];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_push_o   <= 1'b0;
      vector_fetch_o <= 1'b0;
      swtrap_vec_o   <= 1'b0;
    end else if (ce_i) begin
      stack_push_o   <= (state_r == EIL_STACK); // R01
      vector_fetch_o <= (state_r == EIL_VECTOR); // R06
      swtrap_vec_o   <= (state_r == EIL_VECTOR) && svc_trap_r; // R03
    end
  end

  // single-wait slave; ack drops the cycle after it rose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
      wb_dat_o <= '0; // R15 R21
      if (req.adr == `EIL_ADDR_SCR) begin
        wb_dat_o[`EIL_BIT_PEND]  <= pend_r; // R19
        wb_dat_o[`EIL_BIT_EXTEN] <= exten_r;
        wb_dat_o[`EIL_BIT_OSC2]  <= osc2_r;
        wb_dat_o[`EIL_BIT_OSC1]  <= osc1_r;
      end else if (req.adr == `EIL_ADDR_CPU) begin
        wb_dat_o[`EIL_BIT_GMASK]  <= gmask_r;
        wb_dat_o[`EIL_BIT_SWTRAP] <= trap_r;
        wb_dat_o[`EIL_BIT_INSVC]  <= insvc_r;
      end
    end
  end

  vector_clears_a: assert property (@(posedge clk_i) disable iff (rst_i) // R06
    (ce_i && state_r == EIL_VECTOR && !svc_trap_r && !set_req) |=> !pend_r)
    else $error("pending flag not cleared at vector fetch");
  mask_blocks_a: assert property (@(posedge clk_i) disable iff (rst_i) // R04
    (ce_i && state_r == EIL_RUN && (gmask_r || !exten_r) && !trap_r &&
     !(wr_cpu && req.dat[`EIL_BIT_SWTRAP])) |=> state_r != EIL_STACK)
    else $error("external service despite mask");
  entry_seq_a: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    (ce_i && state_r == EIL_RUN && take_ext) |=> ##1 (gmask_r && state_r == EIL_VECTOR))
    else $error("entry sequence wrong");
  reti_restore_a: assert property (@(posedge clk_i) disable iff (rst_i) // R02
    (ce_i && reti_pulse && insvc_r && state_r == EIL_RUN) |=> gmask_r == $past(saved_mask_r))
    else $error("mask not restored");
  fclr_clears_a: assert property (@(posedge clk_i) disable iff (rst_i) // R20
    (ce_i && fclr && !set_req) |=> !pend_r)
    else $error("flag clear ignored");
  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    (ce_i && set_req) |=> pend_r)
    else $error("request lost");
  osc_map_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    (ce_i && osc1_r && osc2_r) |=> (osc_o.osc_int_en && osc_o.osc_ext_en))
    else $error("osc both-set mode wrong");
  edge_only_a: assert property (@(posedge clk_i) disable iff (rst_i) // R08
    (ce_i && !level_mode_i && !irq_lvl_r && !irq_fall) |-> !set_req)
    else $error("held pin relatched in edge mode");
  trap_nomask_a: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    (ce_i && state_r == EIL_RUN && done_pulse && req.dat[`EIL_BIT_SWTRAP])
    |=> state_r == EIL_STACK)
    else $error("trap masked");

  // register view, oscillator modes, per-source latching and service entry

  unused_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    wb_ack_o |-> (wb_dat_o[31:8] == 24'h0))
    else $error("unused read bits not zero");

  fclr_reads_a: assert property (@(posedge clk_i) disable iff (rst_i) // R21
    (wb_ack_o && req.adr == `EIL_ADDR_SCR) |-> !wb_dat_o[`EIL_BIT_FCLR])
    else $error("flag-clear bit reads one");

  pend_ro_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    (ce_i && wr_scr && !fclr && !set_req && state_r == EIL_RUN) |=> pend_r == $past(pend_r))
    else $error("pending flag changed by a write");

  exten_rw_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    (ce_i && wr_scr) |=> exten_r == $past(req.dat[`EIL_BIT_EXTEN]))
    else $error("external enable not written");

  osc_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    (ce_i && !osc1_r) |=> (osc_o.osc_int_en && !osc_o.osc_ext_en))
    else $error("internal oscillator mode wrong");

  osc_ext_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    (ce_i && osc1_r && !osc2_r) |=> (!osc_o.osc_int_en && osc_o.osc_ext_sel))
    else $error("external oscillator mode wrong");

  port_masks_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    (ce_i && !level_mode_i && any_port) |-> !set_req)
    else $error("edge taken while a port pin is high");

  pin_masks_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    (ce_i && !level_mode_i && !irq_lvl_r && (|p_rise)) |-> !set_req)
    else $error("port edge taken while pin is low");

  port_edge_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (ce_i && port_interrupt_option_i && irq_lvl_r && !(|p_lvl_r) && (|p_rise)) |=> pend_r)
    else $error("port edge not latched");

  pin_edge_a: assert property (@(posedge clk_i) disable iff (rst_i) // R07
    (ce_i && irq_fall && !any_port) |=> pend_r)
    else $error("pin edge not latched");

  level_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R09
    (ce_i && level_mode_i && !irq_lvl_r && !any_port) |=> pend_r)
    else $error("held pin level not latched");

  port_level_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    (ce_i && level_mode_i && port_interrupt_option_i && irq_lvl_r && (|p_lvl_r)) |=> pend_r)
    else $error("held port level not latched");

  sync_once_a: assert property (@(posedge clk_i) disable iff (rst_i) // R23
    (ce_i && irq_fall) |=> !irq_fall)
    else $error("one pin transition seen twice");

  take_enter_a: assert property (@(posedge clk_i) disable iff (rst_i) // R05
    (ce_i && state_r == EIL_RUN && take_ext) |=> state_r == EIL_STACK)
    else $error("service not started");

  exten_block_a: assert property (@(posedge clk_i) disable iff (rst_i) // R04
    (!exten_r || gmask_r) |-> !take_ext)
    else $error("service taken while blocked");

  mask_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R22
    (ce_i && pend_r && gmask_r && !fclr && state_r == EIL_RUN) |=> pend_r)
    else $error("masked request dropped");

  push_vec_a: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    (ce_i && stack_push_o) |=> vector_fetch_o)
    else $error("vector fetch does not follow stacking");

  vec_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // R06
    (ce_i && vector_fetch_o) |=> !vector_fetch_o)
    else $error("vector fetch longer than one cycle");

endmodule
`default_nettype wire

// ==== verification/eil_pin_src.sv ====
`timescale 1ns/10ps
`default_nettype none
// far side stand-in: interrupt pin and port pins, levels held between calls
module eil_pin_src (
  input  wire logic       clk_i,
  output logic            irq_n_o,
  output logic [3:0]      port_o
);
  initial begin
    irq_n_o = 1'b1;
    port_o  = 4'h0;
  end
  // pins change only just after an edge; the device synchronises them
  task automatic drive(input logic n, input logic [3:0] p);
    @(posedge clk_i);
    irq_n_o <= n;
    port_o  <= p;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== verification/external_interrupt_logic_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module external_interrupt_logic_tb
  import eil_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        lvl   = 1'b0;
  logic        popt  = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] dat   = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        vec;
  logic        push;
  logic        swv;
  logic        irq_n;
  logic [3:0]  port;
  eil_osc_t    osc;
  logic [7:0]  q;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_vec = 0;
  int          n_push = 0;
  int          n_sw = 0;

  always #25 clk_i = ~clk_i;

  eil_pin_src i_src (.clk_i(clk_i), .irq_n_o(irq_n), .port_o(port));

  eil_ext_irq i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .irq_n_i(irq_n),
    .port_pins_i(port), .level_mode_i(lvl), .port_interrupt_option_i(popt),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .vector_fetch_o(vec), .stack_push_o(push), .swtrap_vec_o(swv), .osc_o(osc));

  always @(posedge clk_i) begin
    if (vec === 1'b1) n_vec++;
    if (push === 1'b1) n_push++;
    if (swv === 1'b1) n_sw++;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // classic cycle: hold the request until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      $display("FAIL %0t no bus answer", $time);
      summarize();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  initial begin
    do_reset();
    rchk(8'h00, 8'h14);
    wb(1'b1, 8'h00, 8'hFF);
    rchk(8'h00, 8'h16);
    chk({5'h0, osc}, 8'h06);
    wb(1'b1, 8'h00, 8'h12);
    repeat (2) @(posedge clk_i);
    chk({5'h0, osc}, 8'h03);
    wb(1'b1, 8'h00, 8'h10);
    repeat (2) @(posedge clk_i);
    chk({5'h0, osc}, 8'h04);
    wb(1'b1, 8'h00, 8'h14);
    $display("test registers done");
    i_src.drive(1'b0, 4'h0);
    rchk(8'h00, 8'h94);
    wb(1'b1, 8'h00, 8'h1C);
    rchk(8'h00, 8'h14);
    i_src.drive(1'b0, 4'h0);
    rchk(8'h00, 8'h14);
    i_src.drive(1'b1, 4'h0);
    i_src.drive(1'b0, 4'h0);
    rchk(8'h00, 8'h94);
    wb(1'b1, 8'h04, 8'h05);
    repeat (6) @(posedge clk_i);
    chk(8'(n_vec), 8'h00);
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b1, 8'h04, 8'h04);
    repeat (6) @(posedge clk_i);
    chk(8'(n_vec), 8'h01);
    chk(8'(n_push), 8'h01);
    rchk(8'h00, 8'h14);
    rchk(8'h04, 8'h11);
    wb(1'b1, 8'h04, 8'h08);
    rchk(8'h04, 8'h00);
    $display("test service done");
    wb(1'b1, 8'h00, 8'h04);
    i_src.drive(1'b1, 4'h0);
    i_src.drive(1'b0, 4'h0);
    wb(1'b1, 8'h04, 8'h04);
    repeat (6) @(posedge clk_i);
    chk(8'(n_vec), 8'h01);
    wb(1'b1, 8'h00, 8'h1C);
    wb(1'b1, 8'h04, 8'h03);
    wb(1'b1, 8'h04, 8'h07);
    repeat (6) @(posedge clk_i);
    chk(8'(n_sw), 8'h01);
    wb(1'b1, 8'h04, 8'h09);
    rchk(8'h04, 8'h01);
    $display("test mask and trap done");
    i_src.drive(1'b1, 4'h0);
    i_src.drive(1'b1, 4'h1);
    rchk(8'h00, 8'h94);
    wb(1'b1, 8'h00, 8'h1C);
    rchk(8'h00, 8'h14);
    i_src.drive(1'b1, 4'h3);
    i_src.drive(1'b0, 4'h3);
    rchk(8'h00, 8'h14);
    i_src.drive(1'b1, 4'h0);
    i_src.drive(1'b0, 4'h0);
    wb(1'b1, 8'h00, 8'h1C);
    i_src.drive(1'b0, 4'h2);
    rchk(8'h00, 8'h14);
    $display("test ports done");
    i_src.drive(1'b1, 4'h0);
    lvl <= 1'b1;
    do_reset();
    i_src.drive(1'b0, 4'h0);
    wb(1'b1, 8'h00, 8'h1C);
    rchk(8'h00, 8'h94);
    i_src.drive(1'b1, 4'h8);
    wb(1'b1, 8'h00, 8'h1C);
    rchk(8'h00, 8'h94);
    i_src.drive(1'b1, 4'h0);
    popt <= 1'b0;
    wb(1'b1, 8'h00, 8'h1C);
    i_src.drive(1'b1, 4'h1);
    rchk(8'h00, 8'h14);
    $display("test level mode done");
    summarize();
  end
endmodule
`default_nettype wire
